// file: core/serial_line_loopback_router.sv
`timescale 1ns/1ps
`include "loopback_map.svh"

// Summary of operation
// [RULE_01] DTE loop: terminal txd kept off line, returned on terminal rxd.
// [RULE_02] DTE loop: terminal scte kept off line, returned on terminal rxc.
// [RULE_03] DTE loop: line txc still passes through to the terminal.
// [RULE_04] DTE loop: line rxd not delivered, sent back out on line txd.
// [RULE_05] DTE loop: line rxc sent back out on line scte.
// [RULE_06] Low-speed control signals keep normal paths in every mode.
// [RULE_07] DCE loop: terminal rxd kept off line, returned on terminal txd.
// [RULE_08] DCE loop: terminal rxc kept off line, returned on terminal scte.
// [RULE_09] DCE loop: line txd not delivered, sent back out on line rxd.
// [RULE_10] DCE loop: line scte sent back out on line rxc.
// [RULE_11] DCE side sources txc and rxc, not scte; it drives txc toward the DTE.
// [RULE_12] DTE controller changes txd on each rising txc edge.
// [RULE_13] Three-clock link: DTE makes rising scte on each rising txc.
// [RULE_14] Three-clock link: DCE samples txd on falling scte edge.
// [RULE_15] Two-clock link: DCE samples txd on falling edge of own txc.
// [RULE_16] Loop select low enables loop-back, high disables it.
// [RULE_17] Role select high gives DCE role, low gives DTE role.
// [RULE_18] Selects are static levels; path switching is purely combinational. The code switches paths from mode_reg, set 3 clk cycles after a select change.

module serial_line_loopback_router
  import loopback_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic line_clk,
  input wire logic loop_select_n,
  input wire logic role_select,
  input wire hs_s term_hs_in,
  output hs_s term_hs_out,
  input wire hs_s line_hs_in,
  output hs_s line_hs_out,
  output hs_s line_hs_oe,
  input wire ls_s term_ls_in,
  output ls_s term_ls_out,
  input wire ls_s line_ls_in,
  output ls_s line_ls_out,
  output ls_s line_ls_oe,
  output route_e route_mode,
  output logic line_clk_alive
);

  // ==========================================================
  // decoding helpers

  // route mode from the two select levels
  function automatic route_e decode_route(input logic loop_n, input logic role);
    route_e r;
    r = DTE_THRU;
    if (role == `ROLE_DCE_LVL) begin
      r = (loop_n == `LOOP_ACTIVE_LVL) ? DCE_LOOP : DCE_THRU;
    end else begin
      r = (loop_n == `LOOP_ACTIVE_LVL) ? DTE_LOOP : DTE_THRU;
    end
    return r;
  endfunction

  // low-speed signals that the given role sources toward the line
  function automatic ls_s ls_drive_mask(input route_e r);
    ls_s m;
    m = '0;
    if ((r == DCE_THRU) || (r == DCE_LOOP)) begin
      m.dsr = 1'b1;
      m.dcd = 1'b1;
      m.cts = 1'b1;
      m.ri = 1'b1;
    end else begin
      m.dtr = 1'b1;
      m.rts = 1'b1;
      m.ll = 1'b1;
      m.rl = 1'b1;
    end
    return m;
  endfunction

  // ==========================================================
  // select capture in the control domain

  logic [`SEL_W-1:0] sel_raw;
  logic [`SEL_W-1:0] sel_sync;
  route_e mode_reg;
  route_e mode_next;

  // loop bit kept inverted so a cleared synchroniser means loop-back off
  assign sel_raw[`SEL_LOOP_BIT] = ~loop_select_n;
  assign sel_raw[`SEL_ROLE_BIT] = role_select;

  level_sync #(
    .W(`SEL_W)
  ) u_sel_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(sel_raw),
    .q(sel_sync)
  );

  // mode follows the settled select levels
  always_comb begin
    mode_next = decode_route(~sel_sync[`SEL_LOOP_BIT], sel_sync[`SEL_ROLE_BIT]); // RULE_16 RULE_17
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= DTE_THRU;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign route_mode = mode_reg;

  // ==========================================================
  // high-speed path switching, no clocked stage in the data path

  // each mode picks sources and line driver enables
  always_comb begin
    term_hs_out = '0;
    line_hs_out = '0;
    line_hs_oe = '0;
    case (mode_reg) // RULE_18
      DTE_THRU: begin
        line_hs_out.txd = term_hs_in.txd;
        line_hs_out.scte = term_hs_in.scte;
        line_hs_oe.txd = 1'b1;
        line_hs_oe.scte = 1'b1;
        term_hs_out.rxd = line_hs_in.rxd;
        term_hs_out.rxc = line_hs_in.rxc;
        term_hs_out.txc = line_hs_in.txc;
      end
      DTE_LOOP: begin
        term_hs_out.rxd = term_hs_in.txd; // RULE_01
        term_hs_out.rxc = term_hs_in.scte; // RULE_02
        term_hs_out.txc = line_hs_in.txc; // RULE_03
        line_hs_out.txd = line_hs_in.rxd; // RULE_04
        line_hs_out.scte = line_hs_in.rxc; // RULE_05
        line_hs_oe.txd = 1'b1;
        line_hs_oe.scte = 1'b1;
      end
      DCE_THRU: begin
        line_hs_out.rxd = term_hs_in.rxd;
        line_hs_out.rxc = term_hs_in.rxc;
        line_hs_out.txc = term_hs_in.txc; // RULE_11
        line_hs_oe.rxd = 1'b1;
        line_hs_oe.rxc = 1'b1;
        line_hs_oe.txc = 1'b1;
        term_hs_out.txd = line_hs_in.txd;
        term_hs_out.scte = line_hs_in.scte;
      end
      DCE_LOOP: begin
        term_hs_out.txd = term_hs_in.rxd; // RULE_07
        term_hs_out.scte = term_hs_in.rxc; // RULE_08
        line_hs_out.rxd = line_hs_in.txd; // RULE_09
        line_hs_out.rxc = line_hs_in.scte; // RULE_10
        line_hs_out.txc = term_hs_in.txc; // RULE_11
        line_hs_oe.rxd = 1'b1;
        line_hs_oe.rxc = 1'b1;
        line_hs_oe.txc = 1'b1;
      end
      default: begin
        term_hs_out = '0;
        line_hs_out = '0;
        line_hs_oe = '0;
      end
    endcase
  end

  // ==========================================================
  // low-speed signals pass straight through in every mode

  // only the role decides which of them are driven onto the line
  always_comb begin
    line_ls_out = term_ls_in; // RULE_06
    term_ls_out = line_ls_in; // RULE_06
    line_ls_oe = ls_drive_mask(mode_reg); // RULE_06
  end

  // ==========================================================
  // line clock domain: a toggle that marks each rising line clock edge

  logic link_tgl_reg;
  logic link_tgl_next;

  always_comb begin
    link_tgl_next = ~link_tgl_reg;
  end

  always_ff @(posedge line_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_tgl_reg <= 1'b0;
    end else begin
      link_tgl_reg <= link_tgl_next;
    end
  end

  // ==========================================================
  // line clock watchdog in the control domain

  logic tgl_sync;
  logic tgl_seen_reg;
  logic tgl_seen_next;
  logic [`WDOG_W-1:0] wdog_reg;
  logic [`WDOG_W-1:0] wdog_next;
  logic alive_reg;
  logic alive_next;
  logic tgl_edge;

  level_sync #(
    .W(1)
  ) u_tgl_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(link_tgl_reg),
    .q(tgl_sync)
  );

  assign tgl_edge = tgl_sync ^ tgl_seen_reg;

  // restart on each rising line clock edge, saturate at the timeout
  always_comb begin
    tgl_seen_next = tgl_sync;
    wdog_next = wdog_reg;
    if (tgl_edge) begin
      wdog_next = '0;
    end else if (wdog_reg < `WDOG_W'(`LINE_CLK_TIMEOUT_CYC)) begin
      wdog_next = wdog_reg + `WDOG_W'(1);
    end
    alive_next = tgl_edge || (wdog_next < `WDOG_W'(`LINE_CLK_TIMEOUT_CYC));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_seen_reg <= 1'b0;
      wdog_reg <= `WDOG_W'(`LINE_CLK_TIMEOUT_CYC);
      alive_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= tgl_seen_next;
      wdog_reg <= wdog_next;
      alive_reg <= alive_next;
    end
  end

  assign line_clk_alive = alive_reg;

  // ==========================================================
  // checks

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!arst_n);

  // select pins held for the settle time
  sequence s_sel_steady;
    ($stable(loop_select_n) && $stable(role_select)) [*3];
  endsequence

  // a line clock edge followed by a quiet stretch
  sequence s_edge_then_quiet;
    tgl_edge ##1 (!tgl_edge) [*2];
  endsequence

  a_dte_loop_data: assert property ( // RULE_01
    (mode_reg == DTE_LOOP) |-> (term_hs_out.rxd == term_hs_in.txd) && (line_hs_out.txd == line_hs_in.rxd))
    else $error("dte loop: terminal txd not returned");

  a_dte_loop_clock: assert property ( // RULE_02
    (mode_reg == DTE_LOOP) |-> (term_hs_out.rxc == term_hs_in.scte) && !line_hs_oe.rxc)
    else $error("dte loop: terminal scte not returned");

  a_dte_txc_pass: assert property ( // RULE_03
    ((mode_reg == DTE_LOOP) || (mode_reg == DTE_THRU)) |-> (term_hs_out.txc == line_hs_in.txc))
    else $error("dte: line txc not passed to terminal");

  a_dte_line_return: assert property ( // RULE_04
    (mode_reg == DTE_LOOP) |-> line_hs_oe.txd && (term_hs_out.rxd != line_hs_in.rxd || term_hs_in.txd == line_hs_in.rxd))
    else $error("dte loop: line rxd leaked to terminal");

  a_dte_scte_return: assert property ( // RULE_05
    (mode_reg == DTE_LOOP) |-> line_hs_oe.scte && (line_hs_out.scte == line_hs_in.rxc))
    else $error("dte loop: line rxc not echoed on scte");

  a_low_speed_pass: assert property ( // RULE_06
    (line_ls_out == term_ls_in) && (term_ls_out == line_ls_in) && ((line_ls_oe ^ ls_drive_mask(mode_reg)) == '0))
    else $error("low-speed path disturbed");

  a_dce_loop_data: assert property ( // RULE_07
    (mode_reg == DCE_LOOP) |-> (term_hs_out.txd == term_hs_in.rxd) && (line_hs_out.rxd == line_hs_in.txd))
    else $error("dce loop: terminal rxd not returned");

  a_dce_loop_clock: assert property ( // RULE_08
    (mode_reg == DCE_LOOP) |-> (term_hs_out.scte == term_hs_in.rxc) && !line_hs_oe.scte)
    else $error("dce loop: terminal rxc not returned");

  a_dce_line_return: assert property ( // RULE_09
    (mode_reg == DCE_LOOP) |-> line_hs_oe.rxd && !line_hs_oe.txd)
    else $error("dce loop: line txd not sent back");

  a_dce_rxc_return: assert property ( // RULE_10
    (mode_reg == DCE_LOOP) |-> line_hs_oe.rxc && (line_hs_out.rxc == line_hs_in.scte))
    else $error("dce loop: line scte not returned on rxc");

  a_clock_source: assert property ( // RULE_11
    line_hs_oe.txc == ((mode_reg == DCE_THRU) || (mode_reg == DCE_LOOP)))
    else $error("txc driven by the wrong role");

  a_select_decode: assert property ( // RULE_16 RULE_17
    s_sel_steady |=> (mode_reg == decode_route($past(loop_select_n), $past(role_select))))
    else $error("mode does not follow select pins");

  a_mode_static: assert property ( // RULE_18
    s_sel_steady ##1 ($stable(loop_select_n) && $stable(role_select)) |=> $stable(mode_reg))
    else $error("mode moved with static selects");

  a_wdog_alive: assert property (
    s_edge_then_quiet |-> ##1 line_clk_alive)
    else $error("line clock lost too early");

endmodule

// file: core/loopback_map.svh
`ifndef LOOPBACK_MAP_SVH
`define LOOPBACK_MAP_SVH

// ==========================================================
// clocking of the control domain
`define CLK_PERIOD_NS 20

// ==========================================================
// line clock watchdog
// least time without a line clock edge before it is called lost
`define LINE_CLK_TIMEOUT_NS 1000
// rounded up to whole control clock cycles
`define LINE_CLK_TIMEOUT_CYC ((`LINE_CLK_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDOG_W 7

// ==========================================================
// select pins and their levels
`define SEL_W 2
`define SEL_LOOP_BIT 0
`define SEL_ROLE_BIT 1
`define LOOP_ACTIVE_LVL 1'b0
`define ROLE_DCE_LVL 1'b1

// ==========================================================
// synchroniser depth and select settling, in control clock cycles
`define SYNC_STAGES 2
`define SEL_SETTLE_CYC 3

`endif

// file: core/loopback_pkg.sv
package loopback_pkg;

  // ==========================================================
  // routing modes, one per role and loop setting
  typedef enum logic [1:0] {
    DTE_THRU,
    DTE_LOOP,
    DCE_THRU,
    DCE_LOOP
  } route_e;

  // ==========================================================
  // high-speed data and clock signals, named from the link circuit
  typedef struct packed {
    logic txd;
    logic scte;
    logic rxd;
    logic rxc;
    logic txc;
  } hs_s;

  // ==========================================================
  // low-speed control and handshake signals
  typedef struct packed {
    logic dtr;
    logic rts;
    logic ll;
    logic rl;
    logic dsr;
    logic dcd;
    logic cts;
    logic ri;
  } ls_s;

endpackage

// file: core/level_sync.sv
`timescale 1ns/1ps
`include "loopback_map.svh"

module level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // two flip-flop synchroniser for levels
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// file: tb/remote_line_model.sv
`timescale 1ns/1ps

// ==========================================================
// remote terminal at the far end of the line
module remote_line_model
  import loopback_pkg::*;
(
  input wire logic run,
  input wire hs_s line_hs_out,
  output logic line_clk,
  output hs_s line_hs_in,
  output logic echo_scte,
  output logic echo_txc,
  output logic far_sent
);
  int seed = 14551;
  logic [1:0] dat = 2'h0;

  // link clock, 160 ns period, stands still low while run is low
  initial begin
    line_clk = 1'b0;
    #3;
    forever begin
      #80;
      line_clk = run ? ~line_clk : 1'b0;
    end
  end

  // far data changes only on the rising clock edge
  always @(posedge line_clk) begin
    dat <= 2'($random(seed));
  end

  // three-clock far dce takes returned txd on the falling edge of returned scte
  always @(negedge line_hs_out.scte) begin
    echo_scte <= line_hs_out.txd;
  end

  // two-clock far dce takes returned txd on the falling edge of its own txc
  always @(negedge line_clk) begin
    echo_txc <= line_hs_out.txd;
    far_sent <= dat[0];
  end

  // far end sources txc and rxc, its echo rises with txc
  assign line_hs_in = {dat[1], line_clk, dat[0], line_clk, line_clk};
endmodule

// file: tb/serial_line_loopback_router_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module serial_line_loopback_router_test
  import loopback_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic loop_select_n = 1'b1;
  logic role_select = 1'b0;
  logic run = 1'b1;
  logic line_clk;
  logic line_clk_alive;
  logic echo_scte;
  logic echo_txc;
  logic far_sent;
  hs_s term_hs_in = '0;
  hs_s term_hs_out;
  hs_s line_hs_in;
  hs_s line_hs_out;
  hs_s line_hs_oe;
  ls_s term_ls_in = '0;
  ls_s term_ls_out;
  ls_s line_ls_in = '0;
  ls_s line_ls_out;
  ls_s line_ls_oe;
  route_e route_mode;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 14551;
  route_e seq [5] = '{DTE_THRU, DTE_LOOP, DCE_LOOP, DCE_THRU, DTE_LOOP};

  always #10 clk = ~clk;

  remote_line_model far_end (.run(run), .line_hs_out(line_hs_out), .line_clk(line_clk),
    .line_hs_in(line_hs_in), .echo_scte(echo_scte), .echo_txc(echo_txc), .far_sent(far_sent));

  serial_line_loopback_router DUT (.clk(clk), .arst_n(arst_n), .line_clk(line_clk),
    .loop_select_n(loop_select_n), .role_select(role_select), .term_hs_in(term_hs_in),
    .term_hs_out(term_hs_out), .line_hs_in(line_hs_in), .line_hs_out(line_hs_out),
    .line_hs_oe(line_hs_oe), .term_ls_in(term_ls_in), .term_ls_out(term_ls_out),
    .line_ls_in(line_ls_in), .line_ls_out(line_ls_out), .line_ls_oe(line_ls_oe),
    .route_mode(route_mode), .line_clk_alive(line_clk_alive));

  // ==========================================================
  // expected routing per mode
  function automatic hs_s exp_term(route_e m, hs_s t, hs_s l);
    hs_s r;
    r = '0;
    case (m)
      DTE_THRU: begin r.rxd = l.rxd; r.rxc = l.rxc; r.txc = l.txc; end
      DTE_LOOP: begin r.rxd = t.txd; r.rxc = t.scte; r.txc = l.txc; end
      DCE_THRU: begin r.txd = l.txd; r.scte = l.scte; end
      default: begin r.txd = t.rxd; r.scte = t.rxc; end
    endcase
    return r;
  endfunction

  function automatic hs_s exp_line(route_e m, hs_s t, hs_s l);
    hs_s r;
    r = '0;
    case (m)
      DTE_THRU: begin r.txd = t.txd; r.scte = t.scte; end
      DTE_LOOP: begin r.txd = l.rxd; r.scte = l.rxc; end
      DCE_THRU: begin r.rxd = t.rxd; r.rxc = t.rxc; r.txc = t.txc; end
      default: begin r.rxd = l.txd; r.rxc = l.scte; r.txc = t.txc; end
    endcase
    return r;
  endfunction

  // ==========================================================
  // select one mode, then random traffic checked in the same cycle
  task automatic run_mode(route_e m);
    logic dce;
    dce = (m == DCE_THRU || m == DCE_LOOP);
    @(posedge clk);
    loop_select_n <= (m == DTE_THRU || m == DCE_THRU);
    role_select <= dce;
    repeat (4) @(posedge clk);
    #1 `CHK(route_mode, m)
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      term_hs_in <= hs_s'(5'($random(seed)));
      term_ls_in <= ls_s'(8'($random(seed)));
      line_ls_in <= ls_s'(8'($random(seed)));
      #1;
      `CHK(term_hs_out, exp_term(m, term_hs_in, line_hs_in))
      `CHK(line_hs_out, exp_line(m, term_hs_in, line_hs_in))
      `CHK(line_hs_oe, hs_s'(dce ? 5'h07 : 5'h18))
      `CHK(term_ls_out, line_ls_in)
      `CHK(line_ls_out, term_ls_in)
      `CHK(line_ls_oe, ls_s'(dce ? 8'h0F : 8'hF0))
    end
    // far dce must get back what it sent, at its falling sample edges
    if (m == DTE_LOOP) begin
      `CHK(echo_scte, far_sent)
      `CHK(echo_txc, far_sent)
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 `CHK(route_mode, DTE_THRU)
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(route_mode, DTE_THRU)
    foreach (seq[i]) run_mode(seq[i]);
    #1 `CHK(line_clk_alive, 1'b1)
    run <= 1'b0;
    repeat (70) @(posedge clk);
    #1 `CHK(line_clk_alive, 1'b0)
    run <= 1'b1;
    repeat (40) @(posedge clk);
    #1 `CHK(line_clk_alive, 1'b1)
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK(route_mode, DTE_THRU)
    `CHK(line_clk_alive, 1'b0)
    arst_n <= 1'b1;
    run_mode(DCE_LOOP);
    final_report();
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
